// ===== design/clock_output_divider.sv
// output clock divider: settings register, period control and pin drive
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// [R1] With duty balance on, the output is kept near 1:1 for every divisor; odd divisors combine two flops, even divisors of 2 or more use wave_q_ff alone.
// [R2] With duty balance off and an odd divisor, the low part is one oscillator cycle shorter than the high part.
// [R3] A divide factor of 0 or 1 passes the oscillator clock straight through.
// [R4] A divide factor above 1 is the integer ratio applied to the oscillator clock.
// [R5] Dropping the clock gate lets the running output period finish before the clock stops.
// [R6] A new divide factor may be written any time but is used only from the next period boundary.
// [R7] The clear/idle bit reads back whether the output has gone idle after disabling.
// [R8] Software fixes the duty balance choice before it raises the clock gate.
// [R9] The clock gate and pin selects decide whether the clock reaches a pin, apart from divider settings.
// [R10] Writing 1 to clear/idle resets the divider at once, forces wave_q_ff low and loads the written divisor.
// [R11] The clear/idle bit reads 1 when idle and 0 while a division by 2 or more has a period in progress.
// [R12] The output invert sits at the very end of the chain and acts at once, so a stopped clock rests at the invert bit, low unless inverted.
// [R13] The output rate depends only on the oscillator and divide factor, not on the system clock divider.
// [R14] The divider runs on the oscillator clock and register writes arrive on that clock, used without any synchronizer.
module clock_output_divider
    import clock_output_divider_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 sfr_wr,
    input  wire logic                 sfr_rd,
    input  wire logic [7:0]           sfr_addr,
    input  wire logic [7:0]           sfr_wdata,
    input  wire logic                 clock_gate,
    input  wire logic [PIN_SEL_W-1:0] pin_select,
    output logic [7:0]                sfr_rdata,
    output logic                      gpio4_clk,
    output logic                      gpio4_clk_oe,
    output logic                      gpio6_clk,
    output logic                      gpio6_clk_oe
);

    sfr_req_t            req;
    clock_out_settings_t settings_ff;
    clock_out_settings_t nxt_settings;
    clock_out_settings_t wr_settings;
    div_state_t          state_ff;
    div_state_t          nxt_state;
    logic [DIV_W-1:0]    act_div_ff;
    logic [DIV_W-1:0]    nxt_act_div;
    logic [7:0]          rdata_ff;
    logic [7:0]          nxt_rdata;
    logic                wave_q_ff;
    logic                wave_qn_ff;
    logic                tog_ff;
    logic                tog_n_ff;
    logic [PIN_SEL_W-1:0] oe_ff;
    logic                hit;
    logic                wr_hit;
    logic                clear_req;
    logic                running;
    logic                pass_mode;
    logic                pass_run;
    logic                div_run;
    logic                boundary;
    logic                period_end;
    logic                phase_high;
    logic                idle;
    logic                wave;
    logic                clk_gen;

    function automatic logic is_pass(input logic [DIV_W-1:0] d);
        is_pass = (d <= DIV_PASS_MAX);
    endfunction

    // register access; the caller drives these on the oscillator clock
    assign req         = '{wr: sfr_wr, rd: sfr_rd, addr: sfr_addr, wdata: sfr_wdata};
    assign hit         = (req.addr == CLOCK_OUT_SETTINGS_ADDR);
    assign wr_hit      = req.wr && hit;
    assign wr_settings = clock_out_settings_t'(req.wdata);
    assign clear_req   = wr_hit && wr_settings.clear_idle;             // [R10]

    assign running   = (state_ff == ST_RUN);
    assign pass_mode = is_pass(act_div_ff);                            // [R3]
    assign pass_run  = running && pass_mode;
    assign div_run   = running && !pass_mode;
    // a passed-through period is a single oscillator cycle
    assign boundary  = pass_run || period_end;

    div_period_counter u_counter (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .clear      (clear_req),
        .count_en   (div_run),
        .div_val    (act_div_ff),
        .period_end (period_end),
        .phase_high (phase_high)
    );

    // settings store; the clear bit is an action and is never held
    always_comb
    begin
        nxt_settings = settings_ff;
        if (wr_hit)
        begin
            nxt_settings            = wr_settings;                     // [R14]
            nxt_settings.clear_idle = 1'b0;
        end
    end

    // period sequencing; oscillator clock only, no system divider term [R13]
    always_comb
    begin
        nxt_state   = state_ff;
        nxt_act_div = act_div_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (clock_gate)
                begin
                    nxt_state   = ST_RUN;
                    nxt_act_div = nxt_settings.div_factor;
                end
            end
            ST_RUN:
            begin
                if (boundary)
                begin
                    nxt_act_div = nxt_settings.div_factor;             // [R6]
                    if (!clock_gate)
                        nxt_state = ST_IDLE;                           // [R5]
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (clear_req)
        begin
            nxt_act_div = wr_settings.div_factor;                      // [R10]
            nxt_state   = clock_gate ? ST_RUN : ST_IDLE;
        end
    end

    // idle unless a division by 2 or more is mid-period
    assign idle = !div_run;                                            // [R7] [R11]

    always_comb
    begin
        nxt_rdata = 8'h00;
        if (req.rd && hit)
        begin
            nxt_rdata                         = settings_ff;
            nxt_rdata[DIVIDER_CLEAR_IDLE_BIT] = idle;                  // [R7]
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            settings_ff <= clock_out_settings_t'(CLOCK_OUT_SETTINGS_RESET);
            state_ff    <= ST_IDLE;
            act_div_ff  <= DIV_ZERO;
            rdata_ff    <= 8'h00;
            oe_ff       <= '0;
        end
        else
        begin
            settings_ff <= nxt_settings;
            state_ff    <= nxt_state;
            act_div_ff  <= nxt_act_div;
            rdata_ff    <= nxt_rdata;
            oe_ff       <= pin_select;                                 // [R9]
        end
    end

    // divided waveform and pass-through toggle, rising edge half
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wave_q_ff <= 1'b0;
            tog_ff    <= 1'b0;
        end
        else
        begin
            wave_q_ff <= clear_req ? 1'b0 : phase_high;                // [R10]
            tog_ff    <= pass_run ? !tog_ff : tog_ff;
        end
    end

    // falling edge copies; mixing them costs some extra jitter
    always_ff @(negedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wave_qn_ff <= 1'b0;
            tog_n_ff   <= 1'b0;
        end
        else
        begin
            wave_qn_ff <= wave_q_ff;
            tog_n_ff   <= tog_ff;
        end
    end

    // odd divisors lose half a cycle of high time to balance the duty
    assign wave = pass_run ? (tog_ff ^ tog_n_ff) :                      // [R3]
                  (settings_ff.duty_balance && act_div_ff[0]) ?
                  (wave_q_ff & wave_qn_ff) : wave_q_ff;                // [R1] [R2]

    // inverter last, acting at once; may clip a pulse when flipped live
    assign clk_gen = wave ^ settings_ff.invert;                        // [R12]

    // clock waveform cannot be a single rising edge flop at full rate
    assign gpio4_clk    = clk_gen;
    assign gpio6_clk    = clk_gen;
    assign gpio4_clk_oe = oe_ff[PIN_SEL_GPIO4];                        // [R9]
    assign gpio6_clk_oe = oe_ff[PIN_SEL_GPIO6];
    assign sfr_rdata    = rdata_ff;

endmodule
`default_nettype wire

// ===== design/clock_output_divider_pkg.sv
// package: constants and types for the output clock divider
package clock_output_divider_pkg;

    // special function register map
    localparam logic [7:0] CLOCK_OUT_SETTINGS_ADDR  = 8'h8f;
    localparam logic [7:0] CLOCK_OUT_SETTINGS_RESET = 8'h00;

    // field positions inside clock_out_settings
    localparam int DIVIDER_CLEAR_IDLE_BIT = 7;
    localparam int OUTPUT_INVERT_BIT      = 6;
    localparam int DUTY_BALANCE_SEL_BIT   = 5;
    localparam int DIV_FACTOR_MSB         = 4;
    localparam int DIV_FACTOR_LSB         = 0;
    localparam int DIV_W                  = 5;

    // divide factors at or below this value pass the oscillator clock through
    localparam logic [DIV_W-1:0] DIV_PASS_MAX = 5'h01;
    localparam logic [DIV_W-1:0] DIV_ZERO     = 5'h00;
    localparam logic [DIV_W-1:0] DIV_ONE      = 5'h01;

    // oscillator clock feeding the divider
    localparam int OSC_FREQ_MHZ = 24;

    // pin select bit positions
    localparam int PIN_SEL_W    = 2;
    localparam int PIN_SEL_GPIO4 = 0;
    localparam int PIN_SEL_GPIO6 = 1;

    typedef struct packed {
        logic             clear_idle;
        logic             invert;
        logic             duty_balance;
        logic [DIV_W-1:0] div_factor;
    } clock_out_settings_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01
    } div_state_t;

endpackage

// ===== design/div_period_counter.sv
// period counter for one output clock period of the divider
`timescale 1ns/10ps
`default_nettype none
module div_period_counter
    import clock_output_divider_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             clear,
    input  wire logic             count_en,
    input  wire logic [DIV_W-1:0] div_val,
    output logic                  period_end,
    output logic                  phase_high
);

    logic [DIV_W-1:0] cnt_ff;
    logic [DIV_W-1:0] nxt_cnt;
    logic [DIV_W-1:0] last_cnt;
    logic [DIV_W-1:0] half_cnt;

    assign last_cnt   = div_val - DIV_ONE;
    // low part first, floor(n/2) cycles; high part ceil(n/2)
    assign half_cnt   = div_val >> 1;
    assign period_end = count_en && (cnt_ff == last_cnt);
    assign phase_high = count_en && (cnt_ff >= half_cnt);    // [R2]
    assign nxt_cnt    = clear ? DIV_ZERO :
                        period_end ? DIV_ZERO :
                        count_en ? cnt_ff + DIV_ONE : cnt_ff;   // [R4]

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            cnt_ff <= DIV_ZERO;
        else
            cnt_ff <= nxt_cnt;
    end

endmodule
`default_nettype wire

// ===== dv/clock_output_divider_bench.sv
// bench: register-level tests of the output clock divider
`timescale 1ns/10ps
`default_nettype none
module clock_output_divider_bench import clock_output_divider_pkg::*; ;
    logic                 sys_clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, clock_gate = 1'b0;
    logic [7:0]           sfr_addr = 8'h00, sfr_wdata = 8'h00;
    logic [PIN_SEL_W-1:0] pin_select = 2'h0;
    logic [7:0]           sfr_rdata, d;
    logic                 gpio4_clk, gpio4_clk_oe, gpio6_clk, gpio6_clk_oe;
    realtime              hi_t, lo_t;
    int                   fails = 0, samples_checked = 0, i;
    localparam logic [7:0] SA = CLOCK_OUT_SETTINGS_ADDR;
    always #4 sys_clk = ~sys_clk;
    clock_output_divider dut_u (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .sfr_wr       (sfr_wr),
        .sfr_rd       (sfr_rd),
        .sfr_addr     (sfr_addr),
        .sfr_wdata    (sfr_wdata),
        .clock_gate   (clock_gate),
        .pin_select   (pin_select),
        .sfr_rdata    (sfr_rdata),
        .gpio4_clk    (gpio4_clk),
        .gpio4_clk_oe (gpio4_clk_oe),
        .gpio6_clk    (gpio6_clk),
        .gpio6_clk_oe (gpio6_clk_oe)
    );
    clock_sink_model sink_u (.clk_in(gpio4_clk), .oe(gpio4_clk_oe), .hi_t(hi_t), .lo_t(lo_t));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        fails += int'(seen !== exp);
        if (seen !== exp)
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    endtask
    // one register access; read data is taken in the cycle it stands
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} <= {w, !w, a, v};
        @(posedge sys_clk);
        {sfr_wr, sfr_rd} <= 2'b00;
        #1 d = sfr_rdata;
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #50us;
        fails++;
        final_report();
    end
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        xfer(1'b0, SA, 8'h00);
        check("reset", d, {1'b1, CLOCK_OUT_SETTINGS_RESET[6:0]});
        xfer(1'b1, SA, 8'h1e);
        xfer(1'b1, 8'h90, 8'hff);
        xfer(1'b0, SA, 8'h00);
        check("stray", d, 8'h9e);
        xfer(1'b0, 8'h90, 8'h00);
        @(posedge sys_clk);
        {clock_gate, pin_select} <= 3'b101; // duty choice fixed by the write above
        for (int n = 2; n < 32; n = 2 * n + 1)
        begin
            xfer(1'b1, SA, 8'h80 | 8'(n));
            repeat (3 * n + 6) @(posedge sys_clk);
            #1 check("period", 32'(int'(hi_t + lo_t)), 32'(8 * n));
            check("low", 32'(int'(lo_t)), 32'(8 * (n / 2)));
        end
        xfer(1'b0, SA, 8'h00);
        check("busy", d[7], 1'b0);
        @(posedge gpio4_clk);
        xfer(1'b1, SA, 8'h02);
        check("hold", gpio4_clk, 1'b1);
        @(negedge gpio4_clk);
        #1 check("hold_hi", 32'(int'(hi_t)), 32'd96);
        xfer(1'b1, SA, 8'h9f);
        repeat (40) @(posedge sys_clk);
        @(posedge gpio4_clk);
        @(posedge sys_clk);
        clock_gate <= 1'b0;
        for (i = 0; i < 50 && d[7] !== 1'b1; i++)
            xfer(1'b0, SA, 8'h00);
        check("idle", d[7], 1'b1);
        check("tail", 32'(int'(hi_t)), 32'd128);
        xfer(1'b1, SA, 8'h5f);
        check("inv", gpio4_clk, 1'b1);
        xfer(1'b0, SA, 8'h00);
        check("inv_rd", d, 8'hdf);
        xfer(1'b1, SA, 8'ha5);
        @(posedge sys_clk);
        clock_gate <= 1'b1; // balance chosen while the gate is still low
        repeat (25) @(posedge sys_clk);
        #1 check("bal_hi", 32'(int'(hi_t)), 32'd20);
        check("bal_lo", 32'(int'(lo_t)), 32'd20);
        xfer(1'b1, SA, 8'h81);
        repeat (5) @(posedge sys_clk);
        #1 check("pass", 32'(int'(hi_t + lo_t)), 32'd8);
        @(posedge sys_clk);
        pin_select <= 2'h3;
        repeat (2) @(posedge sys_clk);
        #1 check("oe_both", {gpio6_clk_oe, gpio4_clk_oe}, 2'h3);
        check("pin6_hi", gpio6_clk, 1'b1);
        #4 check("pin6_lo", gpio6_clk, 1'b0);
        pin_select <= 2'h2;
        repeat (2) @(posedge sys_clk);
        #1 check("oe", {gpio6_clk_oe, gpio4_clk_oe}, 2'h2);
        final_report();
    end
endmodule
`default_nettype wire

// ===== dv/clock_output_divider_chk.sv
// checker: port assertions of the output clock divider
`timescale 1ns/10ps
`default_nettype none
module clock_output_divider_chk import clock_output_divider_pkg::*; (
    input wire logic                 sys_clk,
    input wire logic                 rst,
    input wire logic                 sfr_wr,
    input wire logic                 sfr_rd,
    input wire logic [7:0]           sfr_addr,
    input wire logic [7:0]           sfr_wdata,
    input wire logic                 clock_gate,
    input wire logic [PIN_SEL_W-1:0] pin_select,
    input wire logic [7:0]           sfr_rdata,
    input wire logic                 gpio4_clk,
    input wire logic                 gpio4_clk_oe,
    input wire logic                 gpio6_clk,
    input wire logic                 gpio6_clk_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic hit = sfr_addr == CLOCK_OUT_SETTINGS_ADDR;
    a_oe_from_sel: assert property (##1 {gpio6_clk_oe, gpio4_clk_oe} == $past(pin_select)) else $error("oe");
    a_pins_agree: assert property (gpio4_clk_oe && gpio6_clk_oe |-> gpio4_clk == gpio6_clk) else $error("pins");
    a_rdata_quiet: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00) else $error("rdata");
    a_read_unmapped: assert property (sfr_rd && !hit |=> sfr_rdata == 8'h00) else $error("unmapped");
    a_read_back: assert property (sfr_wr && hit ##1 !sfr_wr ##1 sfr_rd && hit && !sfr_wr
        |=> sfr_rdata[6:0] == $past(sfr_wdata[6:0], 3)) else $error("readback");
    a_stray_write: assert property (sfr_wr && hit ##1 !sfr_wr ##1 sfr_wr && !hit ##1 !sfr_wr ##1 sfr_rd && hit
        |=> sfr_rdata[6:0] == $past(sfr_wdata[6:0], 5)) else $error("stray");
    a_clear_low: assert property (sfr_wr && hit && sfr_wdata[7] && !sfr_wdata[6] && sfr_wdata[4:0] > DIV_PASS_MAX
        |=> ##1 !gpio4_clk) else $error("clear");
    // idle read with a real divisor and no inversion means the pin rests low
    a_idle_rest: assert property (sfr_rdata[7] && !sfr_rdata[6] && sfr_rdata[4:0] > DIV_PASS_MAX |-> !gpio4_clk)
        else $error("rest");
    c_clear: cover property (sfr_wr && hit && sfr_wdata[7]);
    c_idle_read: cover property (sfr_rd && hit ##1 sfr_rdata[7]);
    c_clk_rise: cover property (gpio4_clk_oe && $rose(gpio4_clk));
endmodule
bind clock_output_divider clock_output_divider_chk chk_u (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .sfr_wr       (sfr_wr),
    .sfr_rd       (sfr_rd),
    .sfr_addr     (sfr_addr),
    .sfr_wdata    (sfr_wdata),
    .clock_gate   (clock_gate),
    .pin_select   (pin_select),
    .sfr_rdata    (sfr_rdata),
    .gpio4_clk    (gpio4_clk),
    .gpio4_clk_oe (gpio4_clk_oe),
    .gpio6_clk    (gpio6_clk),
    .gpio6_clk_oe (gpio6_clk_oe)
);
`default_nettype wire

// ===== dv/clock_sink_model.sv
// model of an external chip timing the clock it receives
`timescale 1ns/10ps
`default_nettype none
module clock_sink_model (
    input  wire logic   clk_in,
    input  wire logic   oe,
    output var realtime hi_t,
    output var realtime lo_t
);
    realtime t_edge = 0.0;
    // phases are timed only while the pin is driven; a released pin carries no clock
    always @(clk_in)
    begin
        lo_t   = (oe && clk_in) ? $realtime - t_edge : lo_t;
        hi_t   = (oe && !clk_in) ? $realtime - t_edge : hi_t;
        t_edge = $realtime;
    end
endmodule
`default_nettype wire
